// [exi_consts.vh]
// constants for the external interrupt noise filter block
// Function
// R01: input zero requests on filtered falling edge
// R02: input five requests on filtered falling edge
// R03: fast fixed filter rejects 1, accepts 2
// R04: slow fixed filter rejects 4/fs, accepts 8/fs
// R05: inputs one-three edge codes rise/fall/both/reserved
// R06: input four code 11 is high level
// R07: inputs one-four capture filtered level on request
// R08: captured level refreshed on every request
// R09: fast canceller needs three equal samples
// R10: interval field selects gear clock /1,/4,/8,/16
// R11: slow canceller uses fs/4, two samples
// R12: deep modes halt sampling and requests
// R13: output-mode pin forced low; software disables first
// R14: software waits 12/fs after fast-to-slow
// R15: software waits after slow-to-fast, clears latch
// R16: software picks interval to suit noise
// R17: per-input clock gate, reset zero, stops input
// R18: inputs zero and five fixed, others programmable
// R19: sticky latch, cleared by service or software
// R20: pins synchronised before filtering
`ifndef EXI_CONSTS_VH
`define EXI_CONSTS_VH

// register byte offsets
`define EXI_OFF_GATE    8'h00
`define EXI_OFF_CTL1    8'h04
`define EXI_OFF_CTL4    8'h10
`define EXI_OFF_LATCH   8'h14
`define EXI_OFF_ENABLE  8'h18
`define EXI_ADDR_W      8

// control register fields
`define EXI_F_ES        1:0
`define EXI_F_NC        3:2
`define EXI_F_LVL       4
`define EXI_CH_W        6

// reset values
`define EXI_RST_GATE    6'h00
`define EXI_RST_CFG     2'h0
`define EXI_RST_FILT    1'b0

// edge select codes
`define EXI_ES_RISE     2'h0
`define EXI_ES_FALL     2'h1
`define EXI_ES_BOTH     2'h2
`define EXI_ES_HIGH     2'h3

// sample interval codes
`define EXI_NC_1        2'h0
`define EXI_NC_4        2'h1
`define EXI_NC_8        2'h2
`define EXI_NC_16       2'h3

// operating mode codes on the mode input
`define EXI_MODE_FAST   2'h0
`define EXI_MODE_SLOW   2'h1

// agreeing samples needed
`define EXI_NEED_FAST   2'h3
`define EXI_NEED_TWO    2'h2

// clock rates and the low-frequency divider
`define EXI_SYS_HZ      125000000
`define EXI_LF_HZ       32768
`define EXI_LF_DIV      (`EXI_SYS_HZ / `EXI_LF_HZ)
`define EXI_LF_CNT_W    12
`define EXI_LF_LAST     12'hEE5
`define EXI_FS4_LAST    2'h3

`endif

// [exi_nc.v]
// one noise canceller channel: samples on a tick, accepts agreeing samples
`include "exi_consts.vh"
module exi_nc (
   input  wire       sys_clk,
   input  wire       srst,
   input  wire       run,
   input  wire       smp,
   input  wire       din,
   input  wire [1:0] need,
   output reg        filt
);

   // the two samples before the current one
   reg [1:0] hist;

   // shift samples and accept a level once enough agree
   always @(posedge sys_clk) begin
      if (srst) begin
         hist <= {`EXI_RST_FILT, `EXI_RST_FILT};
         filt <= `EXI_RST_FILT;
      end else if (run && smp) begin // [R12]
         hist <= {hist[0], din};
         if (need == `EXI_NEED_TWO) begin
            // two equal samples in a row
            if (din == hist[0]) begin // [R03] [R04] [R11]
               filt <= din;
            end
         end else begin
            // three equal samples in a row, else noise
            if ((din == hist[0]) && (din == hist[1])) begin // [R09]
               filt <= din;
            end
         end
      end
   end

endmodule

// [exi_top.v]
// external interrupt noise filter with APB register access
`include "exi_consts.vh"
module exi_top (
   input  wire                    sys_clk,
   input  wire                    srst,
   // external interrupt pins
   input  wire                    ext_irq_pin_zero,
   input  wire                    ext_irq_pin_one,
   input  wire                    ext_irq_pin_two,
   input  wire                    ext_irq_pin_three,
   input  wire                    ext_irq_pin_four,
   input  wire                    ext_irq_pin_five,
   // pins switched to output mode by the port logic
   input  wire [`EXI_CH_W-1:0]    pin_is_output,
   // operating mode from power management
   input  wire [1:0]              op_mode,
   // service acknowledge per input from the interrupt logic
   input  wire [`EXI_CH_W-1:0]    irq_ack,
   // requests forwarded to the interrupt logic
   output wire [`EXI_CH_W-1:0]    irq_req,
   // APB slave
   input  wire                    psel,
   input  wire                    penable,
   input  wire                    pwrite,
   input  wire [`EXI_ADDR_W-1:0]  paddr,
   input  wire [31:0]             pwdata,
   output reg  [31:0]             prdata,
   output wire                    pready,
   output wire                    pslverr
);

   // registers
   reg  [`EXI_CH_W-1:0]  ext_irq_clock_gate;  // power_gate_reg contents
   reg  [`EXI_CH_W-1:0]  irq_latch;           // sticky request latch
   reg  [`EXI_CH_W-1:0]  irq_enable;          // forward enable
   reg  [1:0]            edge_sel [1:4];      // edge select, inputs one-four
   reg  [1:0]            smp_sel  [1:4];      // sample interval, inputs one-four
   reg  [4:1]            captured_level_bit;  // filtered level at last request

   // timing
   reg  [3:0]                gck_div;  // gear clock prescaler
   reg  [`EXI_LF_CNT_W-1:0]  lf_cnt;   // low-frequency clock divider
   reg  [1:0]                fs4_cnt;  // fs/4 divider
   wire                      lf_tick;  // one pulse per fs period
   wire                      fs4_tick; // one pulse per four fs periods, in slow mode only

   // mode decode
   wire fast_mode = (op_mode == `EXI_MODE_FAST);
   wire slow_mode = (op_mode == `EXI_MODE_SLOW);
   wire sampling  = fast_mode || slow_mode; // deep modes halt sampling and detection

   // pin vector, synchroniser and filter outputs
   wire [`EXI_CH_W-1:0] pins;
   reg  [`EXI_CH_W-1:0] sync_a;  // first synchroniser stage
   reg  [`EXI_CH_W-1:0] sync_b;  // second synchroniser stage
   wire [`EXI_CH_W-1:0] filt;    // canceller pass signals
   reg  [`EXI_CH_W-1:0] filt_d;  // pass signals one cycle ago
   wire [`EXI_CH_W-1:0] det;     // detected requests this cycle

   // APB decode
   wire                  wr_en;  // write takes effect
   wire                  rd_set; // setup phase of a read
   reg   [`EXI_CH_W-1:0] latch_w1c;

   assign pins = {ext_irq_pin_five, ext_irq_pin_four, ext_irq_pin_three,
                  ext_irq_pin_two, ext_irq_pin_one, ext_irq_pin_zero};

   // sample tick for a gear-clock interval code
   function spl_tick;
      input [1:0] sel;
      input [3:0] cnt;
      begin
         case (sel)
            `EXI_NC_1:  spl_tick = 1'b1;
            `EXI_NC_4:  spl_tick = (cnt[1:0] == 2'h3);
            `EXI_NC_8:  spl_tick = (cnt[2:0] == 3'h7);
            `EXI_NC_16: spl_tick = (cnt == 4'hF);
            default:    spl_tick = 1'b1;
         endcase
      end
   endfunction

   // address is one of the mapped registers
   function addr_ok;
      input [`EXI_ADDR_W-1:0] a;
      begin
         addr_ok = (a[1:0] == 2'h0) && (a <= `EXI_OFF_ENABLE);
      end
   endfunction

   // read value for a mapped address
   function [31:0] rd_val;
      input [`EXI_ADDR_W-1:0] a;
      input [`EXI_CH_W-1:0]   gate;
      input [`EXI_CH_W-1:0]   lat;
      input [`EXI_CH_W-1:0]   ena;
      input [4:0]             ctl;
      begin
         rd_val = 32'h0000_0000;
         if (a == `EXI_OFF_GATE) begin
            rd_val[`EXI_CH_W-1:0] = gate;
         end else if (a == `EXI_OFF_LATCH) begin
            rd_val[`EXI_CH_W-1:0] = lat;
         end else if (a == `EXI_OFF_ENABLE) begin
            rd_val[`EXI_CH_W-1:0] = ena;
         end else if (addr_ok(a)) begin
            rd_val[4:0] = ctl;
         end
      end
   endfunction

   // gear clock prescaler, halted in deep modes
   always @(posedge sys_clk) begin
      if (srst) begin
         gck_div <= 4'h0;
      end else if (fast_mode) begin
         gck_div <= gck_div + 4'h1;
      end
   end

   // low-frequency clock enable and its divide by four
   always @(posedge sys_clk) begin
      if (srst) begin
         lf_cnt  <= {`EXI_LF_CNT_W{1'b0}};
         fs4_cnt <= 2'h0;
      end else begin
         if (lf_tick) begin
            lf_cnt <= {`EXI_LF_CNT_W{1'b0}};
         end else begin
            lf_cnt <= lf_cnt + {{(`EXI_LF_CNT_W-1){1'b0}}, 1'b1};
         end
         if (lf_tick && slow_mode) begin
            fs4_cnt <= fs4_cnt + 2'h1;
         end
      end
   end
   // last count of the divider, at the counter's own width
   assign lf_tick  = (lf_cnt == `EXI_LF_LAST);
   assign fs4_tick = lf_tick && slow_mode && (fs4_cnt == `EXI_FS4_LAST); // [R04] [R11]

   // two-stage synchroniser; output-mode pins read low
   always @(posedge sys_clk) begin
      if (srst) begin
         sync_a <= {`EXI_CH_W{`EXI_RST_FILT}};
         sync_b <= {`EXI_CH_W{`EXI_RST_FILT}};
      end else begin
         sync_a <= pins;                   // [R20]
         sync_b <= sync_a & ~pin_is_output; // [R13]
      end
   end

   // one canceller and detector per input
   genvar i;
   generate
      for (i = 0; i < `EXI_CH_W; i = i + 1) begin : g_ch
         // inputs zero and five have fixed condition and filtering
         localparam FIXED = (i == 0) || (i == 5); // [R18]
         wire [1:0] es;
         wire [1:0] nc;
         wire       smp;
         wire [1:0] need;
         wire       run;
         wire       rise;
         wire       fall;
         if (FIXED) begin : g_fix
            assign es = `EXI_ES_FALL; // [R01] [R02]
            assign nc = `EXI_NC_1;    // [R03]
         end else begin : g_prog
            assign es = edge_sel[i]; // [R05]
            assign nc = smp_sel[i];  // [R10]
         end
         // fast: gear clock interval; slow: fs/4
         assign smp  = fast_mode ? spl_tick(nc, gck_div) : fs4_tick; // [R10] [R11]
         assign need = (FIXED || slow_mode) ? `EXI_NEED_TWO : `EXI_NEED_FAST; // [R09]
         assign run  = sampling && ext_irq_clock_gate[i]; // [R12] [R17]
         exi_nc u_nc (
            .sys_clk (sys_clk),
            .srst    (srst),
            .run     (run),
            .smp     (smp),
            .din     (sync_b[i]),
            .need    (need),
            .filt    (filt[i])
         );
         assign rise = filt[i] & ~filt_d[i];
         assign fall = ~filt[i] & filt_d[i];
         // detection condition per edge select code
         assign det[i] = run && (
            ((es == `EXI_ES_RISE) && rise) ||
            ((es == `EXI_ES_FALL) && fall) ||
            ((es == `EXI_ES_BOTH) && (rise || fall)) ||                // [R05]
            ((i == 4) && (es == `EXI_ES_HIGH) && filt[i])); // [R06]
      end
   endgenerate

   // previous pass signal for edge detection
   always @(posedge sys_clk) begin
      if (srst) begin
         filt_d <= {`EXI_CH_W{`EXI_RST_FILT}};
      end else begin
         filt_d <= filt;
      end
   end

   // APB handshake: zero wait states
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok(paddr);
   assign wr_en   = psel && penable && pwrite && addr_ok(paddr);
   assign rd_set  = psel && !penable && !pwrite;

   // one-to-clear bits written to the latch register
   always @* begin
      latch_w1c = {`EXI_CH_W{1'b0}};
      if (wr_en && (paddr == `EXI_OFF_LATCH)) begin
         latch_w1c = pwdata[`EXI_CH_W-1:0];
      end
   end

   // sticky latch: a new request wins over any clear
   always @(posedge sys_clk) begin
      if (srst) begin
         irq_latch <= {`EXI_CH_W{1'b0}};
      end else begin
         irq_latch <= (irq_latch & ~(latch_w1c | irq_ack)) | det; // [R19]
      end
   end
   assign irq_req = irq_latch & irq_enable; // [R19]

   // level captured on every request for inputs one-four
   always @(posedge sys_clk) begin
      if (srst) begin
         captured_level_bit <= 4'h0;
      end else begin
         // keep bits with no request, load the filtered level where one fires
         captured_level_bit <= (captured_level_bit & ~det[4:1]) |
                               (filt[4:1] & det[4:1]); // [R07] [R08]
      end
   end

   // register writes
   integer k;
   always @(posedge sys_clk) begin
      if (srst) begin
         ext_irq_clock_gate <= `EXI_RST_GATE; // [R17]
         irq_enable         <= {`EXI_CH_W{1'b0}};
         for (k = 1; k <= 4; k = k + 1) begin
            edge_sel[k] <= `EXI_RST_CFG;
            smp_sel[k]  <= `EXI_RST_CFG;
         end
      end else if (wr_en) begin
         if (paddr == `EXI_OFF_GATE) begin
            ext_irq_clock_gate <= pwdata[`EXI_CH_W-1:0];
         end else if (paddr == `EXI_OFF_ENABLE) begin
            irq_enable <= pwdata[`EXI_CH_W-1:0];
         end else if ((paddr >= `EXI_OFF_CTL1) && (paddr <= `EXI_OFF_CTL4)) begin
            // control registers one to four
            edge_sel[paddr[4:2]] <= pwdata[`EXI_F_ES];
            smp_sel[paddr[4:2]]  <= pwdata[`EXI_F_NC];
         end
      end
   end

   // read data captured in the setup phase
   always @(posedge sys_clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_set) begin
         if ((paddr >= `EXI_OFF_CTL1) && (paddr <= `EXI_OFF_CTL4)) begin
            prdata <= rd_val(paddr, ext_irq_clock_gate, irq_latch, irq_enable,
                             {captured_level_bit[paddr[4:2]], smp_sel[paddr[4:2]],
                              edge_sel[paddr[4:2]]});
         end else begin
            prdata <= rd_val(paddr, ext_irq_clock_gate, irq_latch, irq_enable, 5'h00);
         end
      end
   end

endmodule

// [exi_monitor.sv]
// checker on the ports of the external interrupt noise filter
`include "exi_consts.vh"
module exi_monitor (
   input wire logic                   sys_clk,
   input wire logic                   srst,
   input wire logic [1:0]             op_mode,
   input wire logic [`EXI_CH_W-1:0]   irq_ack,
   input wire logic [`EXI_CH_W-1:0]   irq_req,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [`EXI_ADDR_W-1:0] paddr,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // the slave answers every transfer with no wait state
   a_ready_always: assert property (psel |-> pready) else $error("pready low");
   // leaving reset: no request and no read data
   a_reset_quiet: assert property ($fell(srst) |-> irq_req == 6'h00 && prdata == 32'h0)
      else $error("outputs not cleared by reset");
   // error flag marks exactly the unmapped or misaligned accesses
   a_err_decode: assert property (psel && penable |->
      pslverr == (paddr > 8'h18 || paddr[1:0] != 2'h0)) else $error("pslverr wrong");
   // a read of an unmapped place returns zero
   a_bad_rdzero: assert property (psel && !penable && !pwrite && paddr > 8'h18
      |=> prdata == 32'h0) else $error("unmapped read not zero");
   // read data only moves after a read setup
   a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("prdata moved");
   // a request stays up until acknowledged or written
   a_req_sticky: assert property (!psel && irq_ack == 6'h00 |=>
      (irq_req & $past(irq_req)) == $past(irq_req)) else $error("request dropped");
   // deep modes raise nothing new
   a_deep_silent: assert property ((op_mode[1] && !psel)[*3] |=>
      (irq_req & ~$past(irq_req)) == 6'h00) else $error("request in deep mode");
   // acknowledge clears the latch when nothing is sampled
   a_ack_clears: assert property ((irq_ack[0] && op_mode[1] && !psel)[*3] |=>
      !irq_req[0]) else $error("ack did not clear");
endmodule
bind exi_top exi_monitor u_mon (.sys_clk(sys_clk), .srst(srst), .op_mode(op_mode),
   .irq_ack(irq_ack), .irq_req(irq_req), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [exi_pin_src.sv]
// board-level sources that drive the six interrupt pins
module exi_pin_src (
   input  wire logic       sys_clk,
   output      logic [5:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // pins idle high, as with a board pull-up
   initial pin = 6'h3F;
   // settle a pin at a level just after an edge
   task set(input int ch, input logic v);
      pin[ch] <= v;
   endtask
   // invert a pin for n whole cycles; n suits the chosen interval
   task pulse(input int ch, input int n);
      pin[ch] <= ~pin[ch];
      repeat (n) @(posedge sys_clk);
      pin[ch] <= ~pin[ch];
   endtask
   // spike that starts and ends between two rising edges, across the falling edge between them
   task glitch(input int ch);
      #3 pin[ch] = ~pin[ch];
      #2 pin[ch] = ~pin[ch];
   endtask
endmodule

// [exi_top_tb.sv]
// self-checking bench for the external interrupt noise filter
`include "exi_consts.vh"
module exi_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 0;        // 125 MHz clock
   logic        srst = 1;           // synchronous reset
   logic [1:0]  op_mode = 0;        // operating mode
   logic [5:0]  pin_is_output = 0;  // output-mode pins
   logic [5:0]  irq_ack = 0;        // service acknowledge
   logic        psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic        err;
   wire  [5:0]  pin, irq_req;
   wire  [31:0] prdata;
   wire         pready, pslverr;
   int          failures = 0, tests_run = 0, n;
   logic [7:0]  r;
   logic [2:0]  c;
   // rows: input, edge code, start level, end level, request expected
   logic [7:0]  rows [14] = '{8'h05, 8'h02, 8'hA5, 8'h23, 8'h24, 8'h4D, 8'h4A,
                              8'h73, 8'h75, 8'h3A, 8'h9B, 8'h95, 8'h83, 8'h8D};
   always #4 sys_clk = ~sys_clk;
   exi_pin_src u_src (.sys_clk(sys_clk), .pin(pin));
   exi_top u_dut (.sys_clk(sys_clk), .srst(srst), .ext_irq_pin_zero(pin[0]),
      .ext_irq_pin_one(pin[1]), .ext_irq_pin_two(pin[2]), .ext_irq_pin_three(pin[3]),
      .ext_irq_pin_four(pin[4]), .ext_irq_pin_five(pin[5]), .pin_is_output(pin_is_output),
      .op_mode(op_mode), .irq_ack(irq_ack), .irq_req(irq_req), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // verdict and end of run
   task finish_test;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // compare one value
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   // one bus transfer: setup, then access until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      // let one edge pass so the next call does not reassign psel at once
      @(posedge sys_clk);
      if (k >= 50) begin
         failures++;
         finish_test;
      end
   endtask
   task clr;
      apb(1, 8'h14, 32'h3F);
   endtask
   task lat;
      apb(0, 8'h14, 0);
   endtask
   initial begin
      cyc(10);
      srst <= 0;
      cyc(1);
      // every register reads zero after reset
      for (int a = 0; a < 8'h1C; a += 4) begin
         apb(0, a[7:0], 0);
         chk(rd, 0);
      end
      apb(0, 8'h1C, 0);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(1, 8'h02, 1);
      chk(err, 1);
      apb(1, 8'h00, 32'h3F);
      apb(0, 8'h00, 0);
      chk(rd, 32'h3F);
      apb(1, 8'h18, 32'h3F);
      // ordinary edge and level cases
      foreach (rows[i]) begin
         r = rows[i];
         c = r[7:5];
         if (c != 0 && c != 5)
            apb(1, {3'h0, c, 2'h0}, {30'h0, r[4:3]});
         u_src.set(c, r[2]);
         cyc(40);
         clr;
         u_src.set(c, r[1]);
         cyc(40);
         lat;
         chk(rd[c], r[0]);
         chk(irq_req[c], r[0]);
         if (r[0] && c != 0 && c != 5) begin
            apb(0, {3'h0, c, 2'h0}, 0);
            chk(rd[4], r[1]);
         end
      end
      // each sampling interval: short pulse dropped, long one taken
      u_src.set(3, 1);
      for (int k = 0; k < 4; k++) begin
         n = (k == 0) ? 1 : 2 << k;
         apb(1, 8'h0C, {28'h0, k[1:0], 2'h1});
         cyc(80);
         clr;
         u_src.pulse(3, 2 * n - 1);
         cyc(80);
         lat;
         chk(rd[3], 0);
         u_src.pulse(3, 4 * n + 2);
         cyc(80);
         lat;
         chk(rd[3], 1);
      end
      // fixed filter: spike dropped, two-cycle pulse taken
      clr;
      u_src.glitch(0);
      cyc(40);
      lat;
      chk(rd[0], 0);
      u_src.pulse(0, 2);
      cyc(40);
      lat;
      chk(rd[0], 1);
      // acknowledge in deep mode, then a pulse that must be ignored
      op_mode <= 2'h2;
      cyc(3);
      irq_ack <= 6'h01;
      cyc(3);
      irq_ack <= 6'h00;
      cyc(1);
      chk(irq_req[0], 0);
      u_src.pulse(0, 20);
      cyc(20);
      lat;
      chk(rd[0], 0);
      op_mode <= 2'h0;
      cyc(40); // wait out the mode change before clearing
      // clock gate off: input dead
      apb(1, 8'h00, 32'h3E);
      clr;
      u_src.pulse(0, 20);
      cyc(20);
      lat;
      chk(rd[0], 0);
      apb(1, 8'h00, 32'h3F);
      // pin one turned to output with its request path shut first
      apb(1, 8'h18, 32'h3D);
      apb(1, 8'h04, 32'h1);
      cyc(40);
      clr;
      pin_is_output <= 6'h02;
      cyc(40);
      lat;
      chk(rd[1], 1);
      chk(irq_req[1], 0);
      pin_is_output <= 6'h00;
      apb(1, 8'h18, 32'h3F);
      // low-speed mode: a pulse of over eight slow periods is taken
      op_mode <= 2'h1;
      cyc(40);
      clr;
      u_src.pulse(0, 30600);
      cyc(20);
      lat;
      chk(rd[0], 1);
      finish_test;
   end
endmodule
